// ### logic/ssr_pkg.sv
// Constants and types shared by the shadowed static RAM host controller.
// Assumes a 100 MHz sys_clk; every time below is turned into whole cycles.
package ssr_pkg;

    // Clock period and pin widths
    localparam int CLK_NS = 10;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;
    localparam int TW     = 20;  // Width of the cycle timers

    // Times in ns as the device needs them, slowest grade
    localparam int PUR_NS    = 100000;   // powerup_ram_wait
    localparam int PUW_NS    = 5000000;  // powerup_shadow_wait
    localparam int STORE_NS  = 5000000;
    localparam int RECALL_NS = 5000;
    localparam int RD_NS     = 300;      // Read access time
    localparam int WP_NS     = 200;      // Write pulse width
    localparam int SP_NS     = 200;      // Store pulse width
    localparam int SOE_NS    = 20;       // drive_off_before_save
    localparam int OEST_NS   = 10;       // Quiet time after a pulse

    // Least times rounded up to whole cycles
    localparam int PUR_CYC    = (PUR_NS + CLK_NS - 1) / CLK_NS;
    localparam int PUW_CYC    = (PUW_NS + CLK_NS - 1) / CLK_NS;
    localparam int STORE_CYC  = (STORE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RECALL_CYC = (RECALL_NS + CLK_NS - 1) / CLK_NS;
    localparam int SYNC_CYC   = 3;  // Pin register plus two-stage input sync
    localparam int RD_CYC     = (RD_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
    localparam int WP_CYC     = (WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int SP_CYC     = (SP_NS + CLK_NS - 1) / CLK_NS;
    localparam int SOE_CYC    = (SOE_NS + CLK_NS - 1) / CLK_NS;
    localparam int OEST_CYC   = (OEST_NS + CLK_NS - 1) / CLK_NS;

    // Host commands
    typedef enum logic [1:0] {
        OP_READ   = 2'h0,
        OP_WRITE  = 2'h1,
        OP_RECALL = 2'h2,
        OP_STORE  = 2'h3
    } ssr_op_t;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_BOOT  = 3'h0,
        ST_IDLE  = 3'h1,
        ST_SETUP = 3'h2,
        ST_PULSE = 3'h3,
        ST_HOLD  = 3'h4,
        ST_BUSY  = 3'h5
    } ssr_state_t;

endpackage

// ### logic/ssr_timer.sv
// Down-counting cycle timer used for phase lengths and power-up waits.
// Assumes load and ce come from logic on sys_clk.
`timescale 1ns/100ps
`default_nettype none
module ssr_timer #(
    parameter int unsigned    W       = 20,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rstn,
    input  wire logic         ce,
    // Control
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    // Status
    output logic              zero
);

    logic [W-1:0] cnt;

    // Load wins; otherwise count down to zero and stop
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= RST_VAL;
        end else if (ce) begin
            if (load) begin
                cnt <= load_val;
            end else if (cnt != '0) begin
                cnt <= cnt - W'(1);
            end
        end
    end

    assign zero = (cnt == '0);

endmodule
`default_nettype wire

// ### logic/ssr_host.sv
// Host controller driving a 512 x 8 shadowed static RAM over its pins.
// Assumes command inputs on sys_clk; data pins come back asynchronously.
// Contract
// - Chip select low for every access; high means ignored, standby.
// - Read: select and output low, write and shadow access high.
// - Write: select and write low, shadow access high; data latched.
// - Recall: select, output and shadow access low, write high.
// - Store blocked by output low, write high, select high, shadow high.
// - Host waits 100 us after power-up before RAM access.
// - Host waits 5 ms after power-up before shadow operations.
// - Output enable high at least 20 ns before a store begins.
`timescale 1ns/100ps
`default_nettype none
module ssr_host #(
    parameter int unsigned ADDR_W     = ssr_pkg::ADDR_W,
    parameter int unsigned DATA_W     = ssr_pkg::DATA_W,
    parameter int unsigned P_PUR_CYC   = ssr_pkg::PUR_CYC,
    parameter int unsigned P_PUW_CYC   = ssr_pkg::PUW_CYC,
    parameter int unsigned P_STORE_CYC = ssr_pkg::STORE_CYC
) (
    // Clock, reset, enable
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    input  wire logic              ce,
    // Command port
    input  wire logic              cmd_valid,
    input  wire ssr_pkg::ssr_op_t  cmd_op,
    input  wire logic [ADDR_W-1:0] cmd_addr,
    input  wire logic [DATA_W-1:0] cmd_wdata,
    output logic                   cmd_ready,
    // Answer port
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_rdata,
    output logic                   rsp_skipped,
    // Device pins
    output logic [ADDR_W-1:0]      mem_addr,
    output logic                   chip_sel_n,
    output logic                   out_en_n,
    output logic                   write_en_n,
    output logic                   shadow_access_n,
    input  wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0]      data_out,
    output logic                   data_oe
);

    localparam int TW = ssr_pkg::TW;

    ssr_pkg::ssr_state_t state;
    ssr_pkg::ssr_state_t next_state;
    ssr_pkg::ssr_op_t    op;
    logic [DATA_W-1:0]   data_meta;
    logic [DATA_W-1:0]   data_sync;
    logic                dirty;
    logic                t_load;
    logic [TW-1:0]       t_val;
    wire                 t_zero;
    wire                 ram_ok;
    wire                 shadow_ok;

    // Phase timer and power-up timers
    ssr_timer #(.W(TW), .RST_VAL('0)) u_phase (
        .sys_clk  (sys_clk),
        .rstn     (rstn),
        .ce       (ce),
        .load     (t_load),
        .load_val (t_val),
        .zero     (t_zero)
    );
    ssr_timer #(.W(TW), .RST_VAL(TW'(P_PUR_CYC))) u_pur (
        .sys_clk  (sys_clk),
        .rstn     (rstn),
        .ce       (ce),
        .load     (1'b0),
        .load_val ('0),
        .zero     (ram_ok)
    );
    ssr_timer #(.W(TW), .RST_VAL(TW'(P_PUW_CYC))) u_puw (
        .sys_clk  (sys_clk),
        .rstn     (rstn),
        .ce       (ce),
        .load     (1'b0),
        .load_val ('0),
        .zero     (shadow_ok)
    );

    // Command decode
    wire is_rd   = (op == ssr_pkg::OP_READ);
    wire is_wr   = (op == ssr_pkg::OP_WRITE);
    wire is_rc   = (op == ssr_pkg::OP_RECALL);
    wire is_st   = (op == ssr_pkg::OP_STORE);
    wire cmd_nv  = (cmd_op == ssr_pkg::OP_RECALL) || (cmd_op == ssr_pkg::OP_STORE);
    wire take    = (state == ssr_pkg::ST_IDLE) && cmd_valid && (!cmd_nv || shadow_ok);
    wire skip    = take && (cmd_op == ssr_pkg::OP_STORE) && !dirty;
    wire st_pls  = (state == ssr_pkg::ST_PULSE);
    wire pls_end = st_pls && t_zero;
    wire hold_end = (state == ssr_pkg::ST_HOLD) && t_zero;
    wire busy_end = (state == ssr_pkg::ST_BUSY) && t_zero;

    // Pin levels per phase; only the pulse phase pulls controls low
    wire next_cs_n  = !st_pls;
    wire next_oe_n  = !(st_pls && (is_rd || is_rc));
    wire next_we_n  = !(st_pls && (is_wr || is_st));
    wire next_ne_n  = !(st_pls && (is_rc || is_st));
    wire next_doe   = is_wr && ((state == ssr_pkg::ST_SETUP) || st_pls
                      || (state == ssr_pkg::ST_HOLD));
    wire [TW-1:0] pls_ld = is_wr ? TW'(ssr_pkg::WP_CYC - 1)
                         : is_st ? TW'(ssr_pkg::SP_CYC - 1)
                         : TW'(ssr_pkg::RD_CYC - 1);
    wire [TW-1:0] busy_ld = is_st ? TW'(P_STORE_CYC - 1)
                          : TW'(ssr_pkg::RECALL_CYC - 1);

    // Sequencer: setup, pulse, hold, then wait out store or recall
    always_comb begin
        next_state = state;
        t_load     = 1'b0;
        t_val      = '0;
        unique case (state)
            ssr_pkg::ST_BOOT: begin
                if (ram_ok) next_state = ssr_pkg::ST_IDLE;
            end
            ssr_pkg::ST_IDLE: begin
                if (take && !skip) begin
                    next_state = ssr_pkg::ST_SETUP;
                    t_load     = 1'b1;
                    t_val      = TW'(ssr_pkg::SOE_CYC - 1);
                end
            end
            ssr_pkg::ST_SETUP: begin
                if (t_zero) begin
                    next_state = ssr_pkg::ST_PULSE;
                    t_load     = 1'b1;
                    t_val      = pls_ld;
                end
            end
            ssr_pkg::ST_PULSE: begin
                if (t_zero) begin
                    next_state = ssr_pkg::ST_HOLD;
                    t_load     = 1'b1;
                    t_val      = TW'(ssr_pkg::OEST_CYC - 1);
                end
            end
            ssr_pkg::ST_HOLD: begin
                if (t_zero && (is_rc || is_st)) begin
                    next_state = ssr_pkg::ST_BUSY;
                    t_load     = 1'b1;
                    t_val      = busy_ld;
                end else if (t_zero) begin
                    next_state = ssr_pkg::ST_IDLE;
                end
            end
            ssr_pkg::ST_BUSY: begin
                if (t_zero) next_state = ssr_pkg::ST_IDLE;
            end
            default: next_state = ssr_pkg::ST_IDLE;
        endcase
    end

    // State, command latch and write-before-store tracking
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state <= ssr_pkg::ST_BOOT;
            op    <= ssr_pkg::OP_READ;
            dirty <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            if (take) op <= cmd_op;
            if (pls_end && is_wr) begin
                dirty <= 1'b1;
            end else if (pls_end && is_st) begin
                dirty <= 1'b0;
            end
        end
    end

    // Two-stage sync of the returning data pins
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            data_meta <= '0;
            data_sync <= '0;
        end else if (ce) begin
            data_meta <= data_in;
            data_sync <= data_meta;
        end
    end

    // Registered pins
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            chip_sel_n      <= 1'b1;
            out_en_n        <= 1'b1;
            write_en_n      <= 1'b1;
            shadow_access_n <= 1'b1;
            data_oe         <= 1'b0;
            mem_addr        <= '0;
            data_out        <= '0;
        end else if (ce) begin
            chip_sel_n      <= next_cs_n;
            out_en_n        <= next_oe_n;
            write_en_n      <= next_we_n;
            shadow_access_n <= next_ne_n;
            data_oe         <= next_doe;
            if (take) begin
                mem_addr <= cmd_addr;
                data_out <= cmd_wdata;
            end
        end
    end

    // Command handshake and answers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cmd_ready   <= 1'b0;
            rsp_valid   <= 1'b0;
            rsp_skipped <= 1'b0;
            rsp_rdata   <= '0;
        end else if (ce) begin
            cmd_ready   <= (next_state == ssr_pkg::ST_IDLE);
            rsp_valid   <= skip || (hold_end && (is_rd || is_wr)) || busy_end;
            rsp_skipped <= skip;
            if (pls_end && is_rd) rsp_rdata <= data_sync;
        end
    end

    // Cycles since reset, for the power-up checks
    logic [TW-1:0] up_cnt;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            up_cnt <= '0;
        end else if (ce && (up_cnt < TW'(P_PUW_CYC))) begin
            up_cnt <= up_cnt + TW'(1);
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    wire store_lvl = !chip_sel_n && !write_en_n && !shadow_access_n;
    sequence s_store_start;
        $rose(store_lvl);
    endsequence
    sequence s_store_hold;
        (store_lvl && out_en_n && !data_oe)[*8];
    endsequence

    AST_NEVER_ALL_LOW: assert property (
        !(!chip_sel_n && !out_en_n && !write_en_n && !shadow_access_n))
        else $error("all four control lines low");
    AST_SELECT_FOR_ACCESS: assert property (
        (!out_en_n || !write_en_n) |-> !chip_sel_n)
        else $error("access without chip select");
    AST_READ_LEVELS: assert property (
        (!out_en_n && shadow_access_n) |-> write_en_n && !data_oe)
        else $error("read with write enable or data driven");
    AST_WRITE_DATA: assert property (
        (!write_en_n && shadow_access_n) |-> data_oe && $past(data_oe))
        else $error("write without data driven beforehand");
    AST_RECALL_LEVELS: assert property (
        (!shadow_access_n && !out_en_n) |-> write_en_n && !data_oe)
        else $error("recall with wrong levels");
    AST_STORE_OE_QUIET: assert property (
        $fell(write_en_n) && !shadow_access_n |->
        $past(out_en_n, 1) && $past(out_en_n, 2))
        else $error("store begun without output enable high first");
    AST_STORE_PULSE: assert property (s_store_start |-> s_store_hold)
        else $error("store pulse too short or data driven");
    AST_RAM_WAIT: assert property (
        !chip_sel_n |-> up_cnt >= TW'(P_PUR_CYC))
        else $error("access before power-up RAM wait");
    AST_SHADOW_WAIT: assert property (
        !shadow_access_n |-> up_cnt >= TW'(P_PUW_CYC))
        else $error("shadow operation before power-up wait");
    AST_SKIP_ANSWER: assert property (
        (take && (cmd_op == ssr_pkg::OP_STORE) && !dirty) |=> rsp_valid && rsp_skipped
        ##1 chip_sel_n)
        else $error("store without prior write not skipped");

endmodule
`default_nettype wire

// ### dv/ssr_dev_model.sv
// Behavioural shadowed static RAM that answers the host controller's pins.
// Assumes host pins only; sys_clk just paces the pattern on a released bus.
`timescale 1ns/100ps
`default_nettype none
module ssr_dev_model (
    // Pins from the host
    input  wire logic       sys_clk,
    input  wire logic [8:0] mem_addr,
    input  wire logic       chip_sel_n,
    input  wire logic       out_en_n,
    input  wire logic       write_en_n,
    input  wire logic       shadow_access_n,
    input  wire logic [7:0] dq_in,
    // Device side of the data bus and activity counts
    output logic [7:0]      dq_out,
    output logic            dq_drv,
    output int              n_store,
    output int              n_recall
);
    logic [7:0] ram [512];
    logic [7:0] nv [512];
    logic [7:0] idle_pat = 8'h3C;
    logic       written = 1'b0;
    realtime    t_wr, t_rc, t_st, t_oe;
    // Mode decode; all four low matches no mode
    wire sel  = !chip_sel_n;
    wire rd_m = sel && !out_en_n && write_en_n && shadow_access_n;
    wire wr_m = sel && !write_en_n && shadow_access_n;
    wire rc_m = sel && !out_en_n && write_en_n && !shadow_access_n;
    wire st_m = sel && !write_en_n && !shadow_access_n && out_en_n;
    // Drive only in read mode, else a pattern that changes every cycle
    assign dq_drv = rd_m;
    assign dq_out = rd_m ? ram[mem_addr] : idle_pat;
    always @(posedge sys_clk) idle_pat <= idle_pat + 8'h3B;
    // Power-up recall of a known shadow image
    initial begin
        n_store = 0;
        n_recall = 0;
        t_oe = 0;
        for (int i = 0; i < 512; i++) begin
            nv[i] = 8'(i) ^ {i[8], 7'h25};
            ram[i] = nv[i];
        end
    end
    // Start times of write, recall and store modes and of output enable going high
    always @(posedge wr_m) t_wr = $realtime;
    always @(posedge rc_m) t_rc = $realtime;
    always @(posedge st_m) t_st = $realtime;
    always @(posedge out_en_n) t_oe = $realtime;
    // Byte write at the end of the pulse
    always @(negedge wr_m) if ($realtime - t_wr >= 20) begin
        ram[mem_addr] = dq_in;
        written = 1'b1;
    end
    // Recall of the whole array; short pulses ignored
    always @(negedge rc_m) if ($realtime - t_rc >= 20) begin
        for (int i = 0; i < 512; i++) ram[i] = nv[i];
        n_recall++;
    end
    // Store needs a prior write and output enable high 20 ns before
    always @(negedge st_m) if ($realtime - t_st >= 20 && written && t_st - t_oe >= 20) begin
        for (int i = 0; i < 512; i++) nv[i] = ram[i];
        written = 1'b0;
        n_store++;
    end
endmodule
`default_nettype wire

// ### dv/ssr_host_tb.sv
// Self-checking bench for the shadowed static RAM host controller.
// Assumes the behavioural device model on the pins and shortened waits.
`timescale 1ns/100ps
`default_nettype none
module ssr_host_tb;
    localparam int PUR   = 20;
    localparam int LIMIT = 6000;  // Timeout in cycles
    logic             sys_clk = 1'b0;
    logic             rstn = 1'b0;
    logic             ce = 1'b1;
    logic             cmd_valid = 1'b0;
    ssr_pkg::ssr_op_t cmd_op = ssr_pkg::OP_READ;
    logic [8:0]       cmd_addr = 9'h000;
    logic [7:0]       cmd_wdata = 8'h00;
    logic             cmd_ready, rsp_valid, rsp_skipped, data_oe, dq_drv, skp;
    logic             chip_sel_n, out_en_n, write_en_n, shadow_access_n;
    logic [7:0]       rsp_rdata, data_out, dq_out, data_in, got;
    logic [8:0]       mem_addr;
    int               n_errors = 0, compares = 0, cyc = 0, n_store, n_recall;
    always #5 sys_clk = ~sys_clk;
    // Bus level: host data while it drives, else the device side
    assign data_in = data_oe ? data_out : dq_out;
    ssr_host #(.P_PUR_CYC(PUR), .P_PUW_CYC(40), .P_STORE_CYC(30)) dut_u (
        .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .rsp_skipped(rsp_skipped), .mem_addr(mem_addr), .chip_sel_n(chip_sel_n),
        .out_en_n(out_en_n), .write_en_n(write_en_n),
        .shadow_access_n(shadow_access_n), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe));
    ssr_dev_model dev_u (
        .sys_clk(sys_clk), .mem_addr(mem_addr), .chip_sel_n(chip_sel_n),
        .out_en_n(out_en_n), .write_en_n(write_en_n),
        .shadow_access_n(shadow_access_n), .dq_in(data_out), .dq_out(dq_out),
        .dq_drv(dq_drv), .n_store(n_store), .n_recall(n_recall));
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task print_verdict;
        $display("Checks %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Pin watch each cycle once reset has set the pins, and the hang limit
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc > 0) begin
            check(32'(chip_sel_n | out_en_n | write_en_n | shadow_access_n), 1);
            check(32'(data_oe & dq_drv), 0);
            if (!shadow_access_n && !write_en_n) check(32'(out_en_n & ~data_oe), 1);
        end
        if (cyc == LIMIT) begin
            n_errors++;
            print_verdict();
        end
    end
    function automatic logic [7:0] init_val(input logic [8:0] a);
        return a[7:0] ^ {a[8], 7'h25};
    endfunction
    // One command through the command port; holds until taken
    task automatic do_cmd(input ssr_pkg::ssr_op_t op, input logic [8:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_addr <= a;
        cmd_wdata <= d;
        do @(posedge sys_clk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        do @(posedge sys_clk); while (rsp_valid !== 1'b1);
        got = rsp_rdata;
        skp = rsp_skipped;
    endtask
    task automatic t_reset;
        int k;
        k = 0;
        repeat (8) @(posedge sys_clk);
        check({chip_sel_n, out_en_n, write_en_n, shadow_access_n, data_oe}, 5'h1E);
        rstn <= 1'b1;
        do begin
            @(posedge sys_clk);
            k++;
        end while (cmd_ready !== 1'b1);
        check(32'(k >= PUR), 1);
        $display("Test reset done");
    endtask
    task automatic t_boot;
        logic [8:0] al [4];
        al = '{9'h000, 9'h1FF, 9'h100, 9'h0AA};
        foreach (al[i]) begin
            do_cmd(ssr_pkg::OP_READ, al[i], 8'h00);
            check(got, init_val(al[i]));
        end
        $display("Test power-up image done");
    endtask
    task automatic t_skip;
        do_cmd(ssr_pkg::OP_STORE, 9'h000, 8'h00);
        check(skp, 1);
        check(n_store, 0);
        $display("Test store without write done");
    endtask
    task automatic t_write;
        do_cmd(ssr_pkg::OP_WRITE, 9'h1FF, 8'hC3);
        do_cmd(ssr_pkg::OP_WRITE, 9'h0FF, 8'h5A);
        do_cmd(ssr_pkg::OP_READ, 9'h1FF, 8'h00);
        check(got, 8'hC3);
        do_cmd(ssr_pkg::OP_READ, 9'h0FF, 8'h00);
        check(got, 8'h5A);
        $display("Test write and read done");
    endtask
    // Clock enable low in mid write pulse must hold the pins where they are
    task automatic t_freeze;
        fork
            do_cmd(ssr_pkg::OP_WRITE, 9'h0AA, 8'h96);
            begin
                repeat (6) @(posedge sys_clk);
                ce <= 1'b0;
                repeat (31) @(posedge sys_clk);
                check(write_en_n, 0);
                ce <= 1'b1;
            end
        join
        do_cmd(ssr_pkg::OP_READ, 9'h0AA, 8'h00);
        check(got, 8'h96);
        $display("Test clock enable freeze done");
    endtask
    task automatic t_store_recall;
        do_cmd(ssr_pkg::OP_STORE, 9'h000, 8'h00);
        check(skp, 0);
        check(n_store, 1);
        do_cmd(ssr_pkg::OP_STORE, 9'h000, 8'h00);
        check(skp, 1);
        do_cmd(ssr_pkg::OP_WRITE, 9'h1FF, 8'h11);
        do_cmd(ssr_pkg::OP_RECALL, 9'h000, 8'h00);
        check(n_recall, 1);
        do_cmd(ssr_pkg::OP_READ, 9'h1FF, 8'h00);
        check(got, 8'hC3);
        do_cmd(ssr_pkg::OP_READ, 9'h055, 8'h00);
        check(got, init_val(9'h055));
        $display("Test store and recall done");
    endtask
    // Main sequence; shadow commands come after the power-up waits
    initial begin
        t_reset();
        t_boot();
        t_skip();
        t_write();
        t_freeze();
        t_store_recall();
        print_verdict();
    end
endmodule
`default_nettype wire
